// [bench/tb_top.sv]
`timescale 1ns/100ps
`include "tfb_map.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs = 1'b0;
  logic we = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic link_clk = 1'b0;
  logic fsync = 1'b0;
  logic [15:0] ext = 16'h0000;
  logic [15:0] main_in;
  logic [15:0] main_out;
  logic [15:0] main_oe;
  logic local_in = 1'b0;
  logic local_out;
  tfb_pkg::tfb_mem_req_t mreq;
  logic mack;
  logic [31:0] mrd;
  logic slow = 1'b0;
  logic [7:0] lo_rec [16];
  logic [7:0] mo_rec [16];
  logic [15:0] oe_rec [16];
  logic [15:0] sbits [4] = '{16'hAAAA, 16'hCCCC, 16'hF0F0, 16'hFF00};
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;

  // pin level: own drive where enabled, else the outside source
  assign main_in = (main_oe & main_out) | (~main_oe & ext);

  tfb_top #(.SLOTS(16)) u_tfb_top (
    .ref_clk_i(clk), .reset_n_i(rst_n), .cpu_cs_i(cs), .cpu_we_i(we),
    .cpu_addr_i(addr), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
    .link_clk_i(link_clk), .frame_sync_i(fsync), .main_in_i(main_in),
    .main_out_o(main_out), .main_oe_o(main_oe), .local_in_i(local_in),
    .local_out_o(local_out), .mem_req_o(mreq), .mem_ack_i(mack),
    .mem_rdata_i(mrd)
  );
  tfb_mem_model u_tfb_mem_model (
    .ref_clk_i(clk), .reset_n_i(rst_n), .slow_i(slow),
    .mem_req_i(mreq), .mem_ack_o(mack), .mem_rdata_o(mrd)
  );

  // system clock and cycle ceiling
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_mem(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    cs = 1'b1;
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    cs = 1'b0;
    we = 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
    cs = 1'b1;
    addr = a;
    @(negedge clk);
    cs = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // serial frames, slot k bytes: local A5^k, stream s {s,k}
  task automatic run_frames(input int nf, input int sel);
    logic [7:0] lb;
    for (int f = 0; f < nf; f++) begin
      for (int k = 0; k < 16; k++) begin
        for (int b = 7; b >= 0; b--) begin
          lb = 8'hA5 ^ 8'(k);
          link_clk = 1'b0;
          // sync in the last bit makes the next bit edge the frame end
          fsync = (k == 15 && b == 0);
          local_in = lb[b];
          ext = (b >= 4) ? sbits[b-4] : {16{k[b]}};
          repeat (8) @(negedge clk);
          // outputs of this bit were launched at the previous bit edge
          lo_rec[k] = {lo_rec[k][6:0], local_out};
          mo_rec[k] = {mo_rec[k][6:0], main_out[sel]};
          if (b == 7) begin
            oe_rec[k] = main_oe;
          end
          link_clk = 1'b1;
          repeat (8) @(negedge clk);
          fsync = 1'b0;
        end
      end
    end
  endtask

  task automatic t_regs();
    logic [15:0] v;
    logic [15:0] ra [6] = '{`TFB_REG_CTRL, `TFB_REG_LBT, `TFB_REG_M2L,
      `TFB_REG_L2M, `TFB_REG_TXBASE, `TFB_REG_OE_BASE};
    for (int i = 0; i < 6; i++) begin
      reg_rd(ra[i], v);
      chk_reg(v, `TFB_REG_RESET);
      reg_wr(ra[i], 16'h2A5C + 16'(i));
      reg_rd(ra[i], v);
      chk_reg(v, 16'h2A5C + 16'(i));
      reg_wr(ra[i], 16'h0000);
    end
    reg_wr(16'h6006, 16'h1234);
    reg_rd(16'h6006, v);
    chk_reg(v, 16'h0000);
  endtask

  task automatic t_m2l();
    logic [7:0] e;
    logic [15:0] m = 16'h0F0F;
    reg_wr(`TFB_REG_LBT, 16'h0007);
    reg_wr(`TFB_REG_M2L, m);
    run_frames(2, 0);
    for (int k = 1; k < 16; k++) begin
      e = m[k-1] ? {4'h7, 4'(k-1)} : 8'hA5 ^ 8'(k-1);
      if (m[k-1] == m[k]) begin
        chk_reg({8'h00, lo_rec[k]}, {8'h00, e});
      end
    end
  endtask

  task automatic t_l2m();
    for (int n = 0; n < 16; n++) begin
      reg_wr(`TFB_REG_OE_BASE + 16'(2*n), n % 2 == 0 ? 16'h0020 : 16'h0000);
    end
    reg_wr(`TFB_REG_LBT, 16'h0055);
    reg_wr(`TFB_REG_M2L, 16'h00C0);
    reg_wr(`TFB_REG_L2M, 16'h00F0);
    reg_wr(`TFB_REG_CTRL, 16'h0006);
    run_frames(2, 5);
    for (int k = 0; k < 16; k++) begin
      chk_reg(oe_rec[k], k % 2 == 0 ? 16'h0020 : 16'h0000);
    end
    chk_reg({8'h00, mo_rec[6]}, 16'h00A0);
    chk_reg({8'h00, lo_rec[7]}, 16'h00A0);
    reg_wr(`TFB_REG_CTRL, 16'h0000);
    for (int n = 0; n < 16; n++) begin
      reg_wr(`TFB_REG_OE_BASE + 16'(2*n), 16'h0000);
    end
  endtask

  task automatic t_mem();
    logic [20:0] a;
    logic [31:0] d;
    logic [5:0] last [4];
    logic seen [4] = '{default: 1'b0};
    int ntx = 0;
    int nrx = 0;
    int n;
    u_tfb_mem_model.mem[32'h400] = 32'h00008032;
    u_tfb_mem_model.mem[32'h402] = 32'h00000045;
    u_tfb_mem_model.mem[32'h404] = 32'h000080E9;
    u_tfb_mem_model.mem[32'h406] = 32'h00000000;
    u_tfb_mem_model.mem[32'h800] = 32'h01000071;
    u_tfb_mem_model.mem[32'h804] = 32'h02008051;
    u_tfb_mem_model.mem[32'h808] = 32'h0300C061;
    u_tfb_mem_model.mem[32'hC004] = 32'h44332211;
    reg_wr(`TFB_REG_TXTAB, 16'h0010);
    reg_wr(`TFB_REG_TXCNT, 16'h0003);
    reg_wr(`TFB_REG_TXBASE, 16'h0100);
    reg_wr(`TFB_REG_RXTAB, 16'h0020);
    reg_wr(`TFB_REG_RXCNT, 16'h0003);
    reg_wr(`TFB_REG_RXSIZE, 16'h0000);
    reg_wr(`TFB_REG_CTRL, 16'h0001);
    run_frames(6, 0);
    slow = 1'b1;
    run_frames(6, 1);
    chk_reg({8'h00, mo_rec[6]}, 16'h0044);
    reg_wr(`TFB_REG_CTRL, 16'h0000);
    foreach (u_tfb_mem_model.wr_addr_q[i]) begin
      a = 21'(u_tfb_mem_model.wr_addr_q[i]);
      d = u_tfb_mem_model.wr_data_q[i];
      if (a[20:8] == 13'h0040) begin
        n = int'(a[7:6]);
        chk_reg(16'(a[6]), 16'h0000);
        chk_mem(d, n == 0 ? 32'h23232323 : 32'h9E9E9E9E);
        if (seen[n]) begin
          chk_reg(16'(a[5:0]), 16'(last[n] + 6'h04));
        end
        seen[n] = 1'b1;
        last[n] = a[5:0];
        ntx++;
      end else begin
        chk_mem(32'(a) & 32'h001FFFC0, 32'h00008000);
        chk_mem(d, 32'hFFFFFFFF);
        chk_mem(32'(a) & 32'h0000003F, 32'(4 * (nrx + 1)));
        nrx++;
      end
    end
    chk_reg(16'(ntx >= 4), 16'h0001);
    chk_reg(16'(nrx >= 2), 16'h0001);
  endtask

  // main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk_reg(main_oe, 16'h0000);
    t_regs();
    t_m2l();
    t_l2m();
    t_mem();
    finish_test();
  end
endmodule

// [bench/tfb_mem_model.sv]
`timescale 1ns/100ps
module tfb_mem_model (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic slow_i,
  input wire tfb_pkg::tfb_mem_req_t mem_req_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  logic [31:0] mem [int];
  int wr_addr_q [$];
  logic [31:0] wr_data_q [$];
  int wait_cnt;
  int wa;
  // sram: one request at a time, answered at once or three cycles late
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 32'h00000000;
      wait_cnt = 0;
    end else begin
      wa = int'(mem_req_i.addr);
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o; // no stale data off the ack cycle
      if (mem_req_i.req && !mem_ack_o) begin
        if (slow_i && wait_cnt < 3) begin
          wait_cnt = wait_cnt + 1;
        end else begin
          wait_cnt = 0;
          mem_ack_o <= 1'b1;
          if (mem_req_i.we) begin
            mem[wa] = mem_req_i.wdata;
            wr_addr_q.push_back(wa);
            wr_data_q.push_back(mem_req_i.wdata);
          end else if (mem.exists(wa)) begin
            mem_rdata_o <= mem[wa];
          end else begin
            mem_rdata_o <= 32'h00000000;
          end
        end
      end
    end
  end
endmodule

// [rtl/tfb_top.sv]
`timescale 1ns/100ps
`include "tfb_map.svh"
// Function
// - local input bytes may replace frame memory data on a main stream
// - selected slots of one main stream are copied to local output
// - copied data is the pin level, own drive included
// - unselected local output slots carry looped back local input
// - local bytes go to chosen stream in flagged slots when enabled
// - substituted slots drive only when their per-slot enable is set
// - local data reaches transmit only by resampling the driven slots
// - every input slot is written to frame memory of four frames
// - two pages alternate, swapping every four frames
// - only listed channels go out, each to a 64-byte buffer
// - transmit entries are 16 bits: valid, slot, stream
// - entry n picks channel of buffer n; invalid keeps its place
// - buffer n sits at base plus 64 times n
// - shared 8-bit counter steps per period; low 4 bits offset writes
// - receive half fills from memory while other half feeds outputs
// - receive read offset uses low 4 to 8 counter bits by size
// - invalid receive entries are skipped
// - with write-back enabled, read words are overwritten with FFFFFFFFh
// - transfer still running at the next period flags an error
module tfb_top #(
  parameter int SLOTS = 32
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic cpu_cs_i,
  input wire logic cpu_we_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [15:0] cpu_wdata_i,
  output logic [15:0] cpu_rdata_o,
  input wire logic link_clk_i,
  input wire logic frame_sync_i,
  input wire logic [15:0] main_in_i,
  output logic [15:0] main_out_o,
  output logic [15:0] main_oe_o,
  input wire logic local_in_i,
  output logic local_out_o,
  output tfb_pkg::tfb_mem_req_t mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);
  localparam int SW = $clog2(SLOTS);
  localparam int AW = SW + 3;
  logic [15:0] ctrl, lbt, m2l_map, l2m_map, tx_tab, tx_cnt, tx_base;
  logic [15:0] rx_tab, rx_cnt, rx_size;
  logic [15:0] oe_mem [SLOTS];
  logic [127:0] tx_mem [2**AW];
  logic [127:0] rx_mem [2**AW];
  logic oob, page;
  logic [7:0] tx_ptr, rx_ptr;
  logic [1:0] lclk_s, fs_s, li_s;
  logic [15:0] mi_s1, mi_s2;
  logic lclk_d, fs_d, fs_pend, lk_edge;
  logic [2:0] bit_cnt;
  logic [SW-1:0] slot_cnt, nslot;
  logic [1:0] frame_cnt, nframe;
  logic last_bit, last_slot, boundary, period_end, npage;
  logic [7:0] in_sh [16];
  logic [7:0] out_sh [16];
  logic [7:0] loc_sh, loc_out_sh, loc_done, m2l_byte;
  logic [127:0] cap_word, rx_word;
  logic [15:0] oe_q;
  logic m2l_hit;
  tfb_pkg::tfb_dma_t state;
  tfb_pkg::tfb_mem_req_t mreq;
  tfb_pkg::tfb_tx_ent_t tent;
  tfb_pkg::tfb_rx_ent_t rent, rx_ent_q;
  logic [10:0] idx;
  logic [31:0] tx_gather;
  logic tx_last, rx_last, xfer_en, goe, l2m_en, oe_hit, oob_clr;

  assign xfer_en = ctrl[`TFB_CTRL_XFER];
  assign goe = ctrl[`TFB_CTRL_GOE];
  assign l2m_en = ctrl[`TFB_CTRL_L2M];
  assign oe_hit = cpu_addr_i >= `TFB_REG_OE_BASE && !cpu_addr_i[0] &&
    cpu_addr_i < `TFB_REG_OE_BASE + 16'(2 * SLOTS);
  assign oob_clr = cpu_cs_i && cpu_we_i && cpu_addr_i == `TFB_REG_STAT &&
    cpu_wdata_i[`TFB_STAT_OOB];

  // slot test against a 16-bit slot map
  function automatic logic f_in_map(input logic [15:0] m,
                                    input logic [SW-1:0] s);
    return (32'(s) < `TFB_MAP_SLOTS) && m[s[3:0]];
  endfunction
  function automatic logic [20:0] f_base(input logic [15:0] r);
    return {r[14:0], 6'h00};
  endfunction
  function automatic logic [20:0] f_tx_ent(input logic [10:0] n);
    return f_base(tx_tab) + 21'({n, 1'b0});
  endfunction
  function automatic logic [20:0] f_rx_ent(input logic [10:0] n);
    return f_base(rx_tab) + 21'({n, 2'b00});
  endfunction
  // receive word address: aligned base plus masked counter offset
  function automatic logic [20:0] f_rx_buf(input logic [15:0] hi);
    logic [2:0] code;
    logic [20:0] mask;
    code = (rx_size[2:0] > `TFB_MAX_SIZE) ? `TFB_MAX_SIZE : rx_size[2:0];
    mask = (21'h000040 << code) - 21'h000001;
    return (f_base(hi) & ~mask) | (21'({rx_ptr, 2'b00}) & mask);
  endfunction

  // register writes
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= `TFB_REG_RESET;
      lbt <= `TFB_REG_RESET;
      m2l_map <= `TFB_REG_RESET;
      l2m_map <= `TFB_REG_RESET;
      tx_tab <= `TFB_REG_RESET;
      tx_cnt <= `TFB_REG_RESET;
      tx_base <= `TFB_REG_RESET;
      rx_tab <= `TFB_REG_RESET;
      rx_cnt <= `TFB_REG_RESET;
      rx_size <= `TFB_REG_RESET;
    end else if (cpu_cs_i && cpu_we_i) begin
      case (cpu_addr_i)
        `TFB_REG_CTRL: ctrl <= cpu_wdata_i;
        `TFB_REG_LBT: lbt <= cpu_wdata_i;
        `TFB_REG_M2L: m2l_map <= cpu_wdata_i;
        `TFB_REG_L2M: l2m_map <= cpu_wdata_i;
        `TFB_REG_TXTAB: tx_tab <= cpu_wdata_i;
        `TFB_REG_TXCNT: tx_cnt <= cpu_wdata_i;
        `TFB_REG_TXBASE: tx_base <= cpu_wdata_i;
        `TFB_REG_RXTAB: rx_tab <= cpu_wdata_i;
        `TFB_REG_RXCNT: rx_cnt <= cpu_wdata_i;
        `TFB_REG_RXSIZE: rx_size <= cpu_wdata_i;
        default: ;
      endcase
    end
  end

  // per-slot output enables
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < SLOTS; i++) oe_mem[i] <= `TFB_REG_RESET;
    end else if (cpu_cs_i && cpu_we_i && oe_hit) begin
      oe_mem[cpu_addr_i[SW:1]] <= cpu_wdata_i;
    end
  end

  // register reads, unmapped reads return zero
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_rdata_o <= 16'h0000;
    end else if (cpu_cs_i && !cpu_we_i) begin
      case (cpu_addr_i)
        `TFB_REG_CTRL: cpu_rdata_o <= ctrl;
        `TFB_REG_STAT: cpu_rdata_o <= {15'h0000, oob};
        `TFB_REG_LBT: cpu_rdata_o <= lbt;
        `TFB_REG_M2L: cpu_rdata_o <= m2l_map;
        `TFB_REG_L2M: cpu_rdata_o <= l2m_map;
        `TFB_REG_TXTAB: cpu_rdata_o <= tx_tab;
        `TFB_REG_TXCNT: cpu_rdata_o <= tx_cnt;
        `TFB_REG_TXBASE: cpu_rdata_o <= tx_base;
        `TFB_REG_RXTAB: cpu_rdata_o <= rx_tab;
        `TFB_REG_RXCNT: cpu_rdata_o <= rx_cnt;
        `TFB_REG_RXSIZE: cpu_rdata_o <= rx_size;
        default: cpu_rdata_o <= oe_hit ? oe_mem[cpu_addr_i[SW:1]] : 16'h0000;
      endcase
    end
  end

  // pin synchronisers and link clock edge detect
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lclk_s <= 2'h0;
      fs_s <= 2'h0;
      li_s <= 2'h0;
      mi_s1 <= 16'h0000;
      mi_s2 <= 16'h0000;
      lclk_d <= 1'b0;
      fs_d <= 1'b0;
    end else begin
      lclk_s <= {lclk_s[0], link_clk_i};
      fs_s <= {fs_s[0], frame_sync_i};
      li_s <= {li_s[0], local_in_i};
      mi_s1 <= main_in_i;
      mi_s2 <= mi_s1;
      lclk_d <= lclk_s[1];
      fs_d <= fs_s[1];
    end
  end
  assign lk_edge = lclk_s[1] && !lclk_d;

  // bit, slot and frame position; sync forces a frame boundary
  assign last_bit = bit_cnt == 3'h7;
  assign last_slot = slot_cnt == SW'(SLOTS - 1);
  assign boundary = lk_edge && ((last_bit && last_slot) || fs_pend);
  assign period_end = boundary && frame_cnt == `TFB_FRAMES_M1;
  assign nslot = (last_slot || fs_pend) ? '0 : slot_cnt + SW'(1);
  assign nframe = (last_slot || fs_pend) ? frame_cnt + 2'h1 : frame_cnt;
  assign npage = ((last_slot || fs_pend) && frame_cnt == `TFB_FRAMES_M1) ?
    !page : page;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_cnt <= 3'h0;
      slot_cnt <= '0;
      frame_cnt <= 2'h0;
      fs_pend <= 1'b0;
    end else begin
      if (fs_s[1] && !fs_d) fs_pend <= 1'b1;
      else if (lk_edge) fs_pend <= 1'b0;
      if (boundary) begin
        bit_cnt <= 3'h0;
        slot_cnt <= '0;
        frame_cnt <= frame_cnt + 2'h1;
      end else if (lk_edge) begin
        bit_cnt <= bit_cnt + 3'h1;
        if (last_bit) slot_cnt <= nslot;
      end
    end
  end

  // page swap and shared counters at period end
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      page <= 1'b0;
      tx_ptr <= 8'h00;
      rx_ptr <= 8'h00;
    end else if (period_end) begin
      page <= !page;
      if (xfer_en) begin
        tx_ptr <= tx_ptr + 8'h01;
        rx_ptr <= rx_ptr + 8'h01;
      end
    end
  end

  // completed bytes of the slot now ending, pin level included
  always_comb begin
    for (int s = 0; s < 16; s++) begin
      cap_word[s*8 +: 8] = {in_sh[s][6:0], mi_s2[s]};
    end
  end
  assign loc_done = {loc_sh[6:0], li_s[1]};
  assign m2l_byte = cap_word[{lbt[`TFB_LBT_M2L_LSB +: 4], 3'b000} +: 8];
  assign m2l_hit = f_in_map(m2l_map, nslot);

  // capture of every input slot into the filling page
  always_ff @(posedge ref_clk_i) begin
    if (lk_edge && last_bit) begin
      tx_mem[{page, frame_cnt, slot_cnt}] <= cap_word;
    end
  end

  // output page read, one word per slot ahead of use
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) rx_word <= 128'h0;
    else rx_word <= rx_mem[{npage, nframe, nslot}];
  end

  // serial shifters for main and local streams
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int s = 0; s < 16; s++) begin
        in_sh[s] <= 8'h00;
        out_sh[s] <= 8'h00;
      end
      loc_sh <= 8'h00;
      loc_out_sh <= 8'h00;
      main_out_o <= 16'h0000;
      oe_q <= 16'h0000;
      local_out_o <= 1'b0;
    end else if (lk_edge) begin
      loc_sh <= loc_done;
      for (int s = 0; s < 16; s++) begin
        in_sh[s] <= cap_word[s*8 +: 8];
        if (last_bit) begin
          if (l2m_en && 4'(s) == lbt[`TFB_LBT_L2M_LSB +: 4] &&
              f_in_map(l2m_map, nslot)) begin
            out_sh[s] <= loc_done;
            main_out_o[s] <= loc_done[7];
          end else begin
            out_sh[s] <= rx_word[s*8 +: 8];
            main_out_o[s] <= rx_word[s*8+7];
          end
        end else begin
          out_sh[s] <= {out_sh[s][6:0], 1'b0};
          main_out_o[s] <= out_sh[s][6];
        end
      end
      oe_q <= last_bit ? oe_mem[nslot] : oe_mem[slot_cnt];
      if (last_bit) begin
        loc_out_sh <= m2l_hit ? m2l_byte : loc_done;
        local_out_o <= m2l_hit ? m2l_byte[7] : loc_done[7];
      end else begin
        loc_out_sh <= {loc_out_sh[6:0], 1'b0};
        local_out_o <= loc_out_sh[6];
      end
    end
  end
  // general enable cuts every driver at once
  assign main_oe_o = oe_q & {16{goe}};

  // transmit gather of four frames of one channel
  assign tent = mem_rdata_i[15:0];
  assign rent = mem_rdata_i;
  always_comb begin
    for (int f = 0; f < 4; f++) begin
      tx_gather[f*8 +: 8] = tx_mem[{!page, 2'(f), tent.slot[SW-1:0]}]
        [{tent.stream, 3'b000} +: 8];
    end
  end
  assign tx_last = idx == tx_cnt[10:0] - 11'h001;
  assign rx_last = idx == rx_cnt[10:0] - 11'h001;
  assign mem_req_o = mreq;

  // memory transfer sequencer: transmit table, then receive table
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= tfb_pkg::ST_IDLE;
      idx <= 11'h000;
      mreq <= '0;
      rx_ent_q <= '0;
    end else begin
      unique case (state)
        tfb_pkg::ST_IDLE: if (period_end && xfer_en) begin
          idx <= 11'h000;
          if (tx_cnt[10:0] != 11'h000) begin
            state <= tfb_pkg::ST_TX_FETCH;
            mreq <= '{1'b1, 1'b0, f_tx_ent(11'h000), 32'h0};
          end else if (rx_cnt[10:0] != 11'h000) begin
            state <= tfb_pkg::ST_RX_FETCH;
            mreq <= '{1'b1, 1'b0, f_rx_ent(11'h000), 32'h0};
          end
        end
        tfb_pkg::ST_TX_FETCH: if (mem_ack_i) begin
          if (tent.valid) begin
            state <= tfb_pkg::ST_TX_WRITE;
            mreq <= '{1'b1, 1'b1, f_base(tx_base) + 21'({idx, 6'h00}) +
                      21'({tx_ptr[3:0], 2'b00}), tx_gather};
          end else begin
            state <= tfb_pkg::ST_TX_NEXT;
            mreq <= '0;
          end
        end
        tfb_pkg::ST_TX_WRITE: if (mem_ack_i) begin
          state <= tfb_pkg::ST_TX_NEXT;
          mreq <= '0;
        end
        tfb_pkg::ST_TX_NEXT: begin
          if (!tx_last) begin
            idx <= idx + 11'h001;
            state <= tfb_pkg::ST_TX_FETCH;
            mreq <= '{1'b1, 1'b0, f_tx_ent(idx + 11'h001), 32'h0};
          end else if (rx_cnt[10:0] != 11'h000) begin
            idx <= 11'h000;
            state <= tfb_pkg::ST_RX_FETCH;
            mreq <= '{1'b1, 1'b0, f_rx_ent(11'h000), 32'h0};
          end else begin
            state <= tfb_pkg::ST_IDLE;
          end
        end
        tfb_pkg::ST_RX_FETCH: if (mem_ack_i) begin
          if (rent.valid) begin
            rx_ent_q <= rent;
            state <= tfb_pkg::ST_RX_READ;
            mreq <= '{1'b1, 1'b0, f_rx_buf(rent.buf_hi), 32'h0};
          end else begin
            state <= tfb_pkg::ST_RX_NEXT;
            mreq <= '0;
          end
        end
        tfb_pkg::ST_RX_READ: if (mem_ack_i) begin
          if (!rx_ent_q.no_wb) begin
            state <= tfb_pkg::ST_RX_WBACK;
            mreq <= '{1'b1, 1'b1, mreq.addr, `TFB_FILL_WORD};
          end else begin
            state <= tfb_pkg::ST_RX_NEXT;
            mreq <= '0;
          end
        end
        tfb_pkg::ST_RX_WBACK: if (mem_ack_i) begin
          state <= tfb_pkg::ST_RX_NEXT;
          mreq <= '0;
        end
        tfb_pkg::ST_RX_NEXT: begin
          if (rx_last) begin
            state <= tfb_pkg::ST_IDLE;
          end else begin
            idx <= idx + 11'h001;
            state <= tfb_pkg::ST_RX_FETCH;
            mreq <= '{1'b1, 1'b0, f_rx_ent(idx + 11'h001), 32'h0};
          end
        end
      endcase
    end
  end

  // received word spread over four frames of the filling half
  always_ff @(posedge ref_clk_i) begin
    if (state == tfb_pkg::ST_RX_READ && mem_ack_i) begin
      for (int f = 0; f < 4; f++) begin
        rx_mem[{!page, 2'(f), rx_ent_q.slot[SW-1:0]}]
          [{rx_ent_q.stream, 3'b000} +: 8] <= mem_rdata_i[f*8 +: 8];
      end
    end
  end

  // overrun status, a new event wins over the clear
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) oob <= 1'b0;
    else if (period_end && state != tfb_pkg::ST_IDLE) oob <= 1'b1;
    else if (oob_clr) oob <= 1'b0;
  end

  a_page_swap: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    period_end |=> page != $past(page)) else $error("page not swapped");
  a_ptr_step: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    period_end && xfer_en |=> tx_ptr == $past(tx_ptr) + 8'h01 &&
    rx_ptr == $past(rx_ptr) + 8'h01) else $error("counter miss");
  a_tx_offset: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state == tfb_pkg::ST_TX_WRITE && !oob |-> mreq.we &&
    mreq.addr[5:2] == tx_ptr[3:0] && mreq.addr[20:6] ==
    tx_base[14:0] + 15'(idx)) else $error("bad tx address");
  a_tx_skip: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state == tfb_pkg::ST_TX_FETCH && mem_ack_i && !mem_rdata_i[15] |=>
    state == tfb_pkg::ST_TX_NEXT ##1 state != tfb_pkg::ST_TX_WRITE)
    else $error("invalid entry moved");
  a_rx_skip: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state == tfb_pkg::ST_RX_FETCH && mem_ack_i && !mem_rdata_i[15] |=>
    state == tfb_pkg::ST_RX_NEXT) else $error("invalid rx read");
  a_wback_fill: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(state == tfb_pkg::ST_RX_WBACK) |-> mreq.we && mreq.wdata ==
    `TFB_FILL_WORD && mreq.addr == $past(mreq.addr))
    else $error("bad write back");
  a_oob_flag: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    period_end && state != tfb_pkg::ST_IDLE |=> oob)
    else $error("overrun not flagged");
  a_oe_gate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    main_oe_o != 16'h0000 |-> goe && (main_oe_o & ~oe_q) == 16'h0000)
    else $error("drive without enable");
  a_loc_loop: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    lk_edge && last_bit && !m2l_hit |=> local_out_o == $past(loc_done[7]))
    else $error("loopback wrong");
  a_loc_copy: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    lk_edge && last_bit && m2l_hit |=> local_out_o == $past(m2l_byte[7]))
    else $error("copy wrong");
endmodule

// [shared/tfb_map.svh]
`ifndef TFB_MAP_SVH
`define TFB_MAP_SVH
// register offsets
`define TFB_REG_CTRL 16'h6000
`define TFB_REG_STAT 16'h6002
`define TFB_REG_LBT 16'h6020
`define TFB_REG_M2L 16'h6022
`define TFB_REG_L2M 16'h6024
`define TFB_REG_TXTAB 16'h6040
`define TFB_REG_TXCNT 16'h6042
`define TFB_REG_TXBASE 16'h6044
`define TFB_REG_RXTAB 16'h6048
`define TFB_REG_RXCNT 16'h604A
`define TFB_REG_RXSIZE 16'h604C
`define TFB_REG_OE_BASE 16'h7000
// field positions
`define TFB_CTRL_XFER 0
`define TFB_CTRL_GOE 1
`define TFB_CTRL_L2M 2
`define TFB_STAT_OOB 0
`define TFB_LBT_M2L_LSB 0
`define TFB_LBT_L2M_LSB 4
// reset values and fixed figures
`define TFB_REG_RESET 16'h0000
`define TFB_FRAMES_M1 2'h3
`define TFB_MAP_SLOTS 16
`define TFB_MAX_SIZE 3'h4
`define TFB_FILL_WORD 32'hFFFFFFFF
`endif

// [shared/tfb_pkg.sv]
package tfb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_TX_FETCH, ST_TX_WRITE, ST_TX_NEXT,
    ST_RX_FETCH, ST_RX_READ, ST_RX_WBACK, ST_RX_NEXT
  } tfb_dma_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [20:0] addr;
    logic [31:0] wdata;
  } tfb_mem_req_t;
  typedef struct packed {
    logic valid;
    logic [3:0] unused;
    logic [6:0] slot;
    logic [3:0] stream;
  } tfb_tx_ent_t;
  typedef struct packed {
    logic [15:0] buf_hi;
    logic valid;
    logic no_wb;
    logic [2:0] unused;
    logic [6:0] slot;
    logic [3:0] stream;
  } tfb_rx_ent_t;
endpackage
